// file: core/scdsp_top.sv
// apb register block for sample clock delay and sysref phase control
// assumes apb master in pclk domain, sysref already captured to pclk
// Function
// - auto phase bit 1 lets sysref realign divider phase; 0 leaves it; resets 0
// - bits 3:2 set negative sysref skew window, 0 to 1.5 device clocks
// - bits 1:0 set positive sysref skew window, 0 to 1.5 device clocks
// - mode 000 no delay; 010 and 011 fine steps 0..16, 011 low jitter
// - mode 100 all 192 fine steps; 110 adds 128 superfine steps
// - codes 001 and 101 reserved; 101 behaves as 001
// - eight-bit superfine value in 0.25 ps steps, resets zero
// - superfine value used only in modes 2 and 6
// - eight-bit fine value in 1.725 ps steps, resets 0xC0
// - fine value used only in modes 2, 3, 4, 6
//
// Our own choice: register access over APB.
module scdsp_top #(
   parameter int unsigned ADDR_W = 14,
   parameter int unsigned DATA_W = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W/8-1:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sysref_evt,
   output logic divider_realign,
   output scdsp_pkg::scdsp_sync_s sync_cfg,
   output scdsp_pkg::scdsp_delay_s delay_cfg
);
   import scdsp_pkg::*;

   localparam int unsigned IDX_W = 12;
   localparam int unsigned REG_W = 8;

   logic [REG_W-1:0] sync_q;
   logic [2:0] mode_q;
   logic [REG_W-1:0] sf_q;
   logic [REG_W-1:0] fine_q;
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic realign_q;
   scdsp_delay_s dly_d;
   scdsp_delay_s dly_q;
   logic [IDX_W-1:0] idx;
   logic aligned;
   logic upper_zero;
   logic mapped;
   logic hit;
   logic setup_ph;
   logic access_ph;
   logic wr;
   logic rd;
   logic wr_sync;
   logic wr_mode;
   logic wr_sf;
   logic wr_fine;

   ////////////////////////////////////////////////////////////////////
   // elaboration checks: the index and one register byte must fit the buses
   if (ADDR_W < IDX_W + ADDR_SHIFT) begin : g_addr_check
      $error("address bus too narrow for the register index");
   end
   if (DATA_W < REG_W || (DATA_W % 8) != 0) begin : g_data_check
      $error("data bus must be whole bytes, one at least");
   end
   if (FINE_LIMIT_NARROW > FINE_LIMIT_FULL) begin : g_limit_check
      $error("narrow fine limit above the full range");
   end

   ////////////////////////////////////////////////////////////////////
   // one place that knows the map, shared by decode and read mux
   function automatic logic is_reg(input logic [IDX_W-1:0] a);
      is_reg = (a == ADDR_SYNC_CTRL) || (a == ADDR_DLY_MODE) ||
               (a == ADDR_SF_DLY) || (a == ADDR_FINE_DLY);
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
      widen = DATA_W'(v);
   endfunction

   // all inputs passed in, so continuous assigns see every change
   function automatic logic wr_hit(input logic w, input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] a);
      wr_hit = w && (i == a);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // apb decode: zero wait states, unmapped or misaligned gives slverr
   assign idx = paddr[ADDR_SHIFT +: IDX_W];
   assign aligned = (paddr[ADDR_SHIFT-1:0] == '0);
   // a wider address bus must not alias the map onto upper pages
   assign upper_zero = ((paddr >> (ADDR_SHIFT + IDX_W)) == '0);
   assign mapped = is_reg(idx);
   assign hit = mapped && aligned && upper_zero;
   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access_ph && !hit;
   // lane 0 carries every register; a write without it is dropped quietly
   assign wr = access_ph && pwrite && hit && pstrb[0];
   // read captured in setup, so the mux never races the access edge
   assign rd = setup_ph && !pwrite;
   assign wr_sync = wr_hit(wr, idx, ADDR_SYNC_CTRL);
   assign wr_mode = wr_hit(wr, idx, ADDR_DLY_MODE);
   assign wr_sf = wr_hit(wr, idx, ADDR_SF_DLY);
   assign wr_fine = wr_hit(wr, idx, ADDR_FINE_DLY);
   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////
   // registers: one process each, reserved bits never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= SYNC_CTRL_RST;
      end else if (wr_sync) begin
         sync_q <= pwdata[REG_W-1:0] & SYNC_CTRL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= DLY_MODE_RST;
      end else if (wr_mode) begin
         mode_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sf_q <= SF_DLY_RST;
      end else if (wr_sf) begin
         sf_q <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fine_q <= FINE_DLY_RST;
      end else if (wr_fine) begin
         fine_q <= pwdata[REG_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux: refused addresses and reserved bits read as zero
   always_comb begin
      rdata_d = '0;
      if (hit) begin
         case (idx)
            ADDR_SYNC_CTRL: rdata_d = widen(sync_q);
            ADDR_DLY_MODE: rdata_d = widen({5'h00, mode_q});
            ADDR_SF_DLY: rdata_d = widen(sf_q);
            ADDR_FINE_DLY: rdata_d = widen(fine_q);
            default: rdata_d = '0;
         endcase
      end
   end

   // read data captured in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (rd) begin
         prdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode gating
   scdsp_delay_map u_map (
      .mode(scdsp_dmode_e'(mode_q)),
      .fine_raw(fine_q),
      .sf_raw(sf_q),
      .dly(dly_d)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_q <= '0;
      end else begin
         dly_q <= dly_d;
      end
   end
   assign delay_cfg = dly_q;

   ////////////////////////////////////////////////////////////////////
   // skew windows out; relies on source timing
   assign sync_cfg = '{
      auto_phase: sync_q[AUTO_PHASE_BIT],
      neg_skew: scdsp_skew_e'(sync_q[NEG_SKEW_LSB +: 2]),
      pos_skew: scdsp_skew_e'(sync_q[POS_SKEW_LSB +: 2])
   };

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         realign_q <= 1'b0;
      end else begin
         realign_q <= sysref_evt && sync_q[AUTO_PHASE_BIT];
      end
   end
   assign divider_realign = realign_q;
endmodule

// file: core/scdsp_pkg.sv
// package for the sample clock delay and sysref phase control block
// assumes a single apb clock domain, 32-bit data, byte addresses
package scdsp_pkg;
   localparam logic [11:0] ADDR_SYNC_CTRL = 12'h10a;
   localparam logic [11:0] ADDR_DLY_MODE = 12'h110;
   localparam logic [11:0] ADDR_SF_DLY = 12'h111;
   localparam logic [11:0] ADDR_FINE_DLY = 12'h112;
   // 0x10a is not a multiple of four: offsets are indices, byte address is four times
   localparam int unsigned ADDR_SHIFT = 2;
   localparam int unsigned AUTO_PHASE_BIT = 7;
   localparam int unsigned NEG_SKEW_LSB = 2;
   localparam int unsigned POS_SKEW_LSB = 0;
   localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
   localparam logic [7:0] SYNC_CTRL_WMASK = 8'h8f;
   localparam logic [2:0] DLY_MODE_RST = 3'h0;
   localparam logic [7:0] SF_DLY_RST = 8'h00;
   localparam logic [7:0] FINE_DLY_RST = 8'hc0;
   localparam logic [7:0] FINE_LIMIT_NARROW = 8'h10;
   localparam logic [7:0] FINE_LIMIT_FULL = 8'hc0;
   localparam logic [7:0] SF_LIMIT = 8'h80;
   // skew window in half device clocks, direct from the two-bit code
   typedef enum logic [1:0] {
      SKEW_NONE = 2'b00,
      SKEW_HALF = 2'b01,
      SKEW_ONE = 2'b10,
      SKEW_ONE_HALF = 2'b11
   } scdsp_skew_e;
   typedef enum logic [2:0] {
      DMODE_OFF = 3'b000,
      DMODE_RSVD1 = 3'b001,
      DMODE_FINE16 = 3'b010,
      DMODE_FINE16_LJ = 3'b011,
      DMODE_FINE192 = 3'b100,
      DMODE_RSVD5 = 3'b101,
      DMODE_FINE_SF = 3'b110,
      DMODE_RSVD7 = 3'b111
   } scdsp_dmode_e;
   typedef struct packed {
      logic fine_en;
      logic sf_en;
      logic low_jitter;
      logic [7:0] fine_steps;
      logic [7:0] sf_steps;
   } scdsp_delay_s;
   typedef struct packed {
      logic auto_phase;
      scdsp_skew_e neg_skew;
      scdsp_skew_e pos_skew;
   } scdsp_sync_s;
endpackage

// file: core/scdsp_delay_map.sv
// maps delay mode and raw step values to the applied delay controls
// assumes inputs come from the register file, purely combinational
module scdsp_delay_map (
   input scdsp_pkg::scdsp_dmode_e mode,
   input logic [7:0] fine_raw,
   input logic [7:0] sf_raw,
   output scdsp_pkg::scdsp_delay_s dly
);
   import scdsp_pkg::*;

   function automatic logic [7:0] sat(input logic [7:0] v, input logic [7:0] lim);
      sat = (v > lim) ? lim : v;
   endfunction

   always_comb begin
      dly = '0;
      case (mode)
         DMODE_FINE16, DMODE_FINE16_LJ: begin
            dly.fine_en = 1'b1;
            dly.low_jitter = (mode == DMODE_FINE16_LJ);
            dly.fine_steps = sat(fine_raw, FINE_LIMIT_NARROW);
            dly.sf_en = (mode == DMODE_FINE16);
            dly.sf_steps = dly.sf_en ? sat(sf_raw, SF_LIMIT) : 8'h00;
         end
         DMODE_FINE192: begin
            dly.fine_en = 1'b1;
            dly.fine_steps = sat(fine_raw, FINE_LIMIT_FULL);
         end
         DMODE_FINE_SF: begin
            dly.fine_en = 1'b1;
            dly.fine_steps = sat(fine_raw, FINE_LIMIT_FULL);
            dly.sf_en = 1'b1;
            dly.sf_steps = sat(sf_raw, SF_LIMIT);
         end
         // reserved codes act as 001, fine ignored here
         default: dly = '0;
      endcase
   end
endmodule

// file: sim/scdsp_props.sv
// checker for the sample clock delay and sysref block
// assumes bound to scdsp_top, single pclk domain
module scdsp_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic sysref_evt,
   input wire logic divider_realign,
   input wire scdsp_pkg::scdsp_sync_s sync_cfg,
   input wire scdsp_pkg::scdsp_delay_s delay_cfg
);
   import scdsp_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_sync = psel && penable && pwrite && pstrb[0] && paddr == {ADDR_SYNC_CTRL, 2'b00};
   sequence s_armed;
      sysref_evt && sync_cfg.auto_phase;
   endsequence
   ///////////////////////////////////////
   a_realign_fires: assert property (s_armed |=> divider_realign)
      else $error("realign missing");
   a_realign_cause: assert property (divider_realign |-> $past(sysref_evt && sync_cfg.auto_phase))
      else $error("realign without cause");
   a_auto_bit_write: assert property (wr_sync |=> sync_cfg.auto_phase == $past(pwdata[7]))
      else $error("auto phase bit wrong");
   a_neg_skew_write: assert property (wr_sync |=> sync_cfg.neg_skew == $past(pwdata[3:2]))
      else $error("negative window wrong");
   a_pos_skew_write: assert property (wr_sync |=> sync_cfg.pos_skew == $past(pwdata[1:0]))
      else $error("positive window wrong");
   a_narrow_clamp: assert property (delay_cfg.low_jitter |-> delay_cfg.fine_en && delay_cfg.fine_steps <= 8'h10)
      else $error("narrow fine not clamped");
   a_step_limits: assert property (delay_cfg.fine_steps <= 8'hc0 && delay_cfg.sf_steps <= 8'h80)
      else $error("step limit exceeded");
   a_idle_zero: assert property (!delay_cfg.fine_en |-> delay_cfg == '0)
      else $error("delay without fine mode");
endmodule

bind scdsp_top scdsp_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .sysref_evt(sysref_evt),
   .divider_realign(divider_realign), .sync_cfg(sync_cfg), .delay_cfg(delay_cfg));

// file: sim/scdsp_clk_src.sv
// clock source model issuing sysref events
// assumes pclk stands for the captured device clock
module scdsp_clk_src (
   input wire logic pclk,
   output logic sysref_evt
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sysref_evt = 1'b0;
   task automatic pulse();
      @(posedge pclk);
      sysref_evt <= 1'b1;
      @(posedge pclk);
      sysref_evt <= 1'b0;
   endtask
endmodule

// file: sim/scdsp_test.sv
// testbench for scdsp_top
// assumes the clock source model and the bound checker
module scdsp_test;
   timeunit 1ns;
   timeprecision 1ns;
   import scdsp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slv_err;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [3:0] pstrb = 4'hf;
   logic sysref_evt, divider_realign;
   scdsp_sync_s sync_cfg;
   scdsp_delay_s delay_cfg;
   int err_total, num_checks;
   always #25 pclk = ~pclk;
   scdsp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sysref_evt(sysref_evt), .divider_realign(divider_realign), .sync_cfg(sync_cfg), .delay_cfg(delay_cfg));
   scdsp_clk_src u_src (.pclk(pclk), .sysref_evt(sysref_evt));
   ///////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] ix, input logic [7:0] d);
      @(posedge pclk);
      paddr <= {ix, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0000, d};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [18:0] dexp(input logic [2:0] m, input logic [7:0] r);
      logic fe, se;
      logic [7:0] fl;
      fe = m inside {3'd2, 3'd3, 3'd4, 3'd6};
      se = m inside {3'd2, 3'd6};
      fl = m < 3'd4 ? 8'h10 : 8'hc0;
      return {fe, se, m == 3'd3, fe ? (r > fl ? fl : r) : 8'h00, se ? (r > 8'h80 ? 8'h80 : r) : 8'h00};
   endfunction
   task automatic t_sync(input logic [7:0] v);
      xfer(1, ADDR_SYNC_CTRL, v);
      xfer(0, ADDR_SYNC_CTRL, 0);
      chk(q, {24'h0000, v & 8'h8f});
      chk(sync_cfg, {v[7], v[3:0]});
      u_src.pulse();
      #1 chk(divider_realign, v[7]);
   endtask
   task automatic t_modes();
      logic [7:0] rv [2] = '{8'h11, 8'hff};
      foreach (rv[i]) begin
         xfer(1, ADDR_FINE_DLY, rv[i]);
         xfer(1, ADDR_SF_DLY, rv[i]);
         for (int m = 0; m < 8; m++) begin
            xfer(1, ADDR_DLY_MODE, 8'(m));
            @(posedge pclk);
            #1 chk(delay_cfg, dexp(3'(m), rv[i]));
         end
      end
   endtask
   task automatic t_strobe();
      pstrb <= 4'he;
      xfer(1, ADDR_SF_DLY, 8'h55);
      pstrb <= 4'hf;
      xfer(0, ADDR_SF_DLY, 0);
      chk(q, 32'h0000_0000);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #500_000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, ADDR_SYNC_CTRL, 0);
      chk(q, 0);
      xfer(0, ADDR_DLY_MODE, 0);
      chk(q, 0);
      xfer(0, ADDR_SF_DLY, 0);
      chk(q, 0);
      xfer(0, ADDR_FINE_DLY, 0);
      chk(q, 32'h0000_00c0);
      t_strobe();
      t_sync(8'hff);
      t_sync(8'h76);
      xfer(0, 12'h10b, 0);
      chk(q, 32'h0000_0000);
      chk(slv_err, 1'b1);
      t_modes();
      report_and_stop();
   end
endmodule
